// File: design/tpc_top.sv
// Purpose: wide timer, period timer and capture/compare unit behind apb
// Assumes: pclk is the instruction clock; event pin is asynchronous
// Notes:   pwm waveform and compare pin actions are not built here
//
// Behaviour
// - oscillator enable bit drives the low-power timer oscillator, which runs in sleep
// - mode 1011 resets wide timer on compare match
// - trigger reset never sets the wide timer overflow flag
// - software write to wide timer beats a coincident trigger reset
// - wide timer bytes survive every reset; only trigger clears them
// - wide timer control clears on power-on reset only
// - writing either wide timer byte clears its prescaler
// - period prescale 00 divides 1, 01 by 4, 1x by 16
// - period timer counts up to period value, then wraps with match pulse
// - presetn reset sets period to all ones and clears count; por_n alone leaves them
// - match pulses through 4-bit postscaler set period timer flag
// - period timer runs only while its on bit is set
// - period pre/postscalers clear on count write, control write, reset
// - pre-postscaler match pulse goes to serial port as shift clock
// - mode 0000 off and reset; 0100-0111 select capture edges
// - modes 1000-1010 compare, 11xx pwm; compare match sets unit flag
// - control bits 5:4 hold the two low duty bits
// - capture copies wide timer to capture pair and sets unit flag
// - new capture overwrites unread capture pair
// - edge detector watches pin level even when pin is output
// - capture prescaler clears when off or not capture; not on switch
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module tpc_top
  import tpc_pkg::*;
#(
  parameter int WT_PRESCALE_MAX = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        event_pin,
  output logic             timer_osc_enable,
  output logic             shift_clock_match,
  output logic             special_trigger
);

  // apb access
  logic       wr_en;
  logic       rd_en;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic       known;
  assign idx   = paddr[9:2];
  assign wbyte = pwdata[7:0];
  assign wr_en = psel && penable && pwrite && !pready;
  assign rd_en = psel && !penable;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  function automatic tpc_class_type mode_class(input logic [3:0] m);
    if (m[3:2] == 2'b11)
      return TPC_CLASS_PWM;
    else if (m[3])
      return TPC_CLASS_CMP;
    else if (m[2])
      return TPC_CLASS_CAP;
    else
      return TPC_CLASS_OFF;
  endfunction

  // registers
  logic [7:0]  gint_q;
  logic [7:0]  flags_q;
  logic [7:0]  enables_q;
  logic [5:0]  wt_ctrl_q;
  logic [15:0] wt_q;
  logic [2:0]  wt_pre_q;
  logic [7:0]  pt_q;
  logic [6:0]  pt_ctrl_q;
  logic [7:0]  period_q;
  logic [3:0]  pt_pre_q;
  logic [3:0]  pt_post_q;
  logic [5:0]  cu_ctrl_q;
  logic [15:0] cap_q;
  logic [3:0]  cap_pre_q;

  logic wr_wt_lo;
  logic wr_wt_hi;
  logic wr_pt;
  logic wr_ptc;
  assign wr_wt_lo = wr_en && hit(idx, IDX_WT_LO);
  assign wr_wt_hi = wr_en && hit(idx, IDX_WT_HI);
  assign wr_pt    = wr_en && hit(idx, IDX_PT_COUNT);
  assign wr_ptc   = wr_en && hit(idx, IDX_PT_CTRL);

  always_comb begin
    unique case (idx)
      IDX_GINT, IDX_PIFLAGS, IDX_WT_LO, IDX_WT_HI, IDX_WT_CTRL, IDX_PT_COUNT,
      IDX_PT_CTRL, IDX_CAP_LO, IDX_CAP_HI, IDX_CU_CTRL, IDX_PIENABLES,
      IDX_PT_PERIOD: known = 1'b1;
      default:       known = 1'b0;
    endcase
  end

  // wide timer prescale: 1,2,4,8
  logic [2:0] wt_pre_mask;
  logic       wt_tick;
  logic       wt_wrap;
  always_comb begin
    case (wt_ctrl_q[5:4])
      2'b00:   wt_pre_mask = 3'h0;
      2'b01:   wt_pre_mask = 3'h1;
      2'b10:   wt_pre_mask = 3'h3;
      default: wt_pre_mask = 3'h7;
    endcase
  end
  assign wt_tick = wt_ctrl_q[WT_ON_BIT] && ((wt_pre_q & wt_pre_mask) == wt_pre_mask);
  assign wt_wrap = wt_tick && (wt_q == 16'hffff);

  // compare unit
  tpc_class_type ucls;
  logic          cmp_match;
  logic          trig;
  assign ucls      = mode_class(cu_ctrl_q[3:0]);
  assign cmp_match = (ucls == TPC_CLASS_CMP) && (wt_q == cap_q);
  assign trig      = cmp_match && (cu_ctrl_q[3:0] == M_CMP_TRIG);

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      wt_ctrl_q <= 6'h00;
    end else if (wr_en && hit(idx, IDX_WT_CTRL)) begin
      wt_ctrl_q <= wbyte[5:0];
    end
  end

  // wide timer holds across resets; no reset term at all
  always_ff @(posedge pclk) begin
    if (wr_wt_lo) begin
      wt_q[7:0] <= wbyte;
    end else if (wr_wt_hi) begin
      wt_q[15:8] <= wbyte;
    end else if (trig) begin
      wt_q <= 16'h0000;
    end else if (wt_tick) begin
      wt_q <= wt_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wt_pre_q <= 3'h0;
    end else if (wr_wt_lo || wr_wt_hi || !wt_ctrl_q[WT_ON_BIT]) begin
      wt_pre_q <= 3'h0;
    end else begin
      wt_pre_q <= (wt_pre_q == 3'(WT_PRESCALE_MAX - 1)) ? 3'h0 : wt_pre_q + 3'h1;
    end
  end

  // period timer
  logic [3:0] pt_pre_last;
  logic       pt_inc;
  logic       pt_match;
  logic       post_term;
  always_comb begin
    case (pt_ctrl_q[1:0])
      2'b00:   pt_pre_last = 4'h0;
      2'b01:   pt_pre_last = 4'h3;
      default: pt_pre_last = 4'hf;
    endcase
  end
  assign pt_inc    = pt_ctrl_q[PT_ON_BIT] && (pt_pre_q == pt_pre_last);
  assign pt_match  = pt_inc && (pt_q == period_q);
  assign post_term = pt_match && (pt_post_q == pt_ctrl_q[6:3]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pt_q      <= ZERO8;
      period_q  <= PERIOD_RESET;
      pt_ctrl_q <= 7'h00;
    end else begin
      if (wr_pt) begin
        pt_q <= wbyte;
      end else if (pt_match) begin
        pt_q <= ZERO8;
      end else if (pt_inc) begin
        pt_q <= pt_q + 8'h01;
      end
      if (wr_ptc) begin
        pt_ctrl_q <= wbyte[6:0];
      end
      if (wr_en && hit(idx, IDX_PT_PERIOD)) begin
        period_q <= wbyte;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pt_pre_q  <= 4'h0;
      pt_post_q <= 4'h0;
    end else if (wr_pt || wr_ptc) begin
      pt_pre_q  <= 4'h0;
      pt_post_q <= 4'h0;
    end else begin
      if (pt_ctrl_q[PT_ON_BIT]) begin
        pt_pre_q <= (pt_pre_q == pt_pre_last) ? 4'h0 : pt_pre_q + 4'h1;
      end
      if (post_term) begin
        pt_post_q <= 4'h0;
      end else if (pt_match) begin
        pt_post_q <= pt_post_q + 4'h1;
      end
    end
  end

  // event pin: two-flop sync, then edge detect on second stage and a history flop
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_h_q;
  logic rise;
  logic fall;
  logic cap_evt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_h_q  <= 1'b0;
    end else begin
      pin_s1_q <= event_pin;
      pin_s2_q <= pin_s1_q;
      pin_h_q  <= pin_s2_q;
    end
  end
  assign rise = pin_s2_q && !pin_h_q;
  assign fall = !pin_s2_q && pin_h_q;

  always_comb begin
    case (cu_ctrl_q[3:0])
      M_CAP_FALL:   cap_evt = fall;
      M_CAP_RISE:   cap_evt = rise;
      M_CAP_RISE4:  cap_evt = rise && (cap_pre_q[1:0] == 2'h3);
      M_CAP_RISE16: cap_evt = rise && (cap_pre_q == 4'hf);
      default:      cap_evt = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_pre_q <= 4'h0;
    end else if (ucls != TPC_CLASS_CAP) begin
      cap_pre_q <= 4'h0;
    end else if (rise) begin
      cap_pre_q <= cap_pre_q + 4'h1;
    end
  end

  // capture/duty pair and unit control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cu_ctrl_q <= 6'h00;
      cap_q     <= 16'h0000;
    end else begin
      if (wr_en && hit(idx, IDX_CU_CTRL)) begin
        cu_ctrl_q <= wbyte[5:0];
      end
      if (cap_evt) begin
        cap_q <= wt_q;
      end else if (wr_en && hit(idx, IDX_CAP_LO)) begin
        cap_q[7:0] <= wbyte;
      end else if (wr_en && hit(idx, IDX_CAP_HI)) begin
        cap_q[15:8] <= wbyte;
      end
    end
  end

  // flags: hardware set wins over software clear
  logic [7:0] flag_set;
  always_comb begin
    flag_set          = 8'h00;
    flag_set[FLAG_WT] = wt_wrap && !trig && !wr_wt_lo && !wr_wt_hi;
    flag_set[FLAG_PT] = post_term;
    flag_set[FLAG_CU] = cap_evt || cmp_match;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q   <= 8'h00;
      enables_q <= 8'h00;
      gint_q    <= 8'h00;
    end else begin
      if (wr_en && hit(idx, IDX_PIFLAGS)) begin
        flags_q <= (wbyte & 8'hcf) | flag_set;
      end else begin
        flags_q <= flags_q | flag_set;
      end
      if (wr_en && hit(idx, IDX_PIENABLES)) begin
        enables_q <= wbyte & 8'hcf;
      end
      if (wr_en && hit(idx, IDX_GINT)) begin
        gint_q <= wbyte;
      end
    end
  end

  // outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_osc_enable  <= 1'b0;
      shift_clock_match <= 1'b0;
      special_trigger   <= 1'b0;
    end else begin
      timer_osc_enable  <= wt_ctrl_q[WT_OSC_BIT];
      shift_clock_match <= pt_match;
      special_trigger   <= trig;
    end
  end

  // apb slave: one wait state, data registered in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !known;
      if (rd_en) begin
        case (idx)
          IDX_GINT:      prdata <= {24'h000000, gint_q};
          IDX_PIFLAGS:   prdata <= {24'h000000, flags_q};
          IDX_WT_LO:     prdata <= {24'h000000, wt_q[7:0]};
          IDX_WT_HI:     prdata <= {24'h000000, wt_q[15:8]};
          IDX_WT_CTRL:   prdata <= {26'h0000000, wt_ctrl_q};
          IDX_PT_COUNT:  prdata <= {24'h000000, pt_q};
          IDX_PT_CTRL:   prdata <= {25'h0000000, pt_ctrl_q};
          IDX_CAP_LO:    prdata <= {24'h000000, cap_q[7:0]};
          IDX_CAP_HI:    prdata <= {24'h000000, cap_q[15:8]};
          IDX_CU_CTRL:   prdata <= {26'h0000000, cu_ctrl_q};
          IDX_PIENABLES: prdata <= {24'h000000, enables_q};
          IDX_PT_PERIOD: prdata <= {24'h000000, period_q};
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // checks
  a_trig_clears_timer: assert property (@(posedge pclk) disable iff (!presetn)
    trig && !wr_wt_lo && !wr_wt_hi |=> wt_q == 16'h0000) else $error("trigger did not clear wide timer");
  a_trig_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
    trig && !(wr_en && idx == IDX_PIFLAGS) |=> flags_q[FLAG_WT] == $past(flags_q[FLAG_WT]))
    else $error("trigger set overflow flag");
  a_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
    trig && wr_wt_lo |=> wt_q[7:0] == $past(wbyte)) else $error("trigger beat a timer write");
  a_pt_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    pt_match && !wr_pt |=> pt_q == 8'h00 && shift_clock_match) else $error("period wrap wrong");
  a_pt_stopped: assert property (@(posedge pclk) disable iff (!presetn)
    !pt_ctrl_q[PT_ON_BIT] && !wr_pt |=> $stable(pt_q)) else $error("period timer ran while off");
  a_pre_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ptc |=> pt_pre_q == 4'h0 && pt_post_q == 4'h0) else $error("scalers not cleared");
  a_cap_copy: assert property (@(posedge pclk) disable iff (!presetn)
    cap_evt |=> cap_q == $past(wt_q) && flags_q[FLAG_CU]) else $error("capture missed");
  a_cap_pre_off: assert property (@(posedge pclk) disable iff (!presetn)
    ucls != TPC_CLASS_CAP |=> cap_pre_q == 4'h0) else $error("capture prescaler kept count");
  a_post_flag: assert property (@(posedge pclk) disable iff (!presetn)
    post_term |=> flags_q[FLAG_PT]) else $error("postscaler flag missed");

endmodule

// File: shared/tpc_pkg.sv
// Purpose: constants for the timer pair and capture unit
// Assumes: apb byte address is four times the register index
// Notes:   indices kept as printed
package tpc_pkg;
  localparam logic [7:0]  IDX_GINT      = 8'h0b;
  localparam logic [7:0]  IDX_PIFLAGS   = 8'h0c;
  localparam logic [7:0]  IDX_WT_LO     = 8'h0e;
  localparam logic [7:0]  IDX_WT_HI     = 8'h0f;
  localparam logic [7:0]  IDX_WT_CTRL   = 8'h10;
  localparam logic [7:0]  IDX_PT_COUNT  = 8'h11;
  localparam logic [7:0]  IDX_PT_CTRL   = 8'h12;
  localparam logic [7:0]  IDX_CAP_LO    = 8'h15;
  localparam logic [7:0]  IDX_CAP_HI    = 8'h16;
  localparam logic [7:0]  IDX_CU_CTRL   = 8'h17;
  localparam logic [7:0]  IDX_PIENABLES = 8'h8c;
  localparam logic [7:0]  IDX_PT_PERIOD = 8'h92;
  localparam logic [7:0]  PERIOD_RESET  = 8'hff;
  localparam logic [7:0]  ZERO8         = 8'h00;
  localparam int          FLAG_WT       = 0;
  localparam int          FLAG_PT       = 1;
  localparam int          FLAG_CU       = 2;
  localparam int          WT_ON_BIT     = 0;
  localparam int          WT_OSC_BIT    = 3;
  localparam int          PT_ON_BIT     = 2;
  localparam logic [3:0]  M_OFF         = 4'h0;
  localparam logic [3:0]  M_CAP_FALL    = 4'h4;
  localparam logic [3:0]  M_CAP_RISE    = 4'h5;
  localparam logic [3:0]  M_CAP_RISE4   = 4'h6;
  localparam logic [3:0]  M_CAP_RISE16  = 4'h7;
  localparam logic [3:0]  M_CMP_SET     = 4'h8;
  localparam logic [3:0]  M_CMP_CLR     = 4'h9;
  localparam logic [3:0]  M_CMP_SOFT    = 4'ha;
  localparam logic [3:0]  M_CMP_TRIG    = 4'hb;
  localparam int          OSC_MAX_KHZ   = 200;
  typedef enum logic [1:0] {
    TPC_CLASS_OFF = 2'b00,
    TPC_CLASS_CAP = 2'b01,
    TPC_CLASS_CMP = 2'b10,
    TPC_CLASS_PWM = 2'b11
  } tpc_class_type;
endpackage

// File: sim/timer_pair_with_capture_unit_test.sv
// Purpose: self-checking bench for the timer pair and capture unit
// Assumes: wide timer uses the internal clock only
// Notes:   expectations come from the register model and counts kept here
`timescale 1ns/1ps
module timer_pair_with_capture_unit_test;
  import tpc_pkg::*;
  logic        pclk, presetn, por_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, event_pin, timer_osc_enable, shift_clock_match, special_trigger;
  int          fail_count = 0, tests_run = 0, cyc = 0, trig_n = 0, p, k, d, n0;
  int          pulse_cyc[$];
  logic [7:0]  mdl[int];
  logic [7:0]  rdat;
  logic        rerr;
  logic [15:0] v;

  tpc_top i_tpc_top (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_pin(event_pin), .timer_osc_enable(timer_osc_enable), .shift_clock_match(shift_clock_match),
    .special_trigger(special_trigger));
  tpc_pin_model i_tpc_pin_model (.pclk(pclk), .timer_osc_enable(timer_osc_enable), .event_pin(event_pin),
    .osc_clock());

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (shift_clock_match === 1'b1) pulse_cyc.push_back(cyc);
    if (special_trigger === 1'b1) trig_n <= trig_n + 1;
    if (cyc > 40000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    rdat = prdata[7:0];
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    mdl[idx] = wd;
    apb(1'b1, idx, wd);
  endtask

  task automatic rd(input logic [7:0] idx, input string what, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(what, {8'h00, rdat}, {8'h00, exp});
  endtask

  task automatic wait_pulses(input int n);
    int t;
    t = pulse_cyc.size() + n;
    while (pulse_cyc.size() < t) @(posedge pclk);
  endtask

  task automatic pin_pulse();
    i_tpc_pin_model.drive(1'b1);
    i_tpc_pin_model.drive(1'b0);
  endtask

  initial begin
    {psel, penable, pwrite, presetn, por_n} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    void'($urandom(52));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    rd(IDX_PT_PERIOD, "period reset", PERIOD_RESET);
    rd(IDX_PT_COUNT, "count reset", ZERO8);
    rd(IDX_PT_CTRL, "pctrl reset", ZERO8);
    rd(IDX_WT_CTRL, "wctrl reset", ZERO8);
    rd(8'h40, "unmapped read", ZERO8);
    check("unmapped err", {15'h0000, rerr}, 16'h0001);
    wr(IDX_PIENABLES, 8'h07);
    rd(IDX_PIENABLES, "enables", mdl[IDX_PIENABLES]);
    // stopped wide timer on the internal clock, oscillator on
    wr(IDX_WT_CTRL, 8'h08);
    repeat (2) @(posedge pclk);
    check("osc enable", {15'h0000, timer_osc_enable}, 16'h0001);
    for (int m = 4; m < 8; m++) begin
      v = 16'($urandom);
      wr(IDX_WT_LO, v[7:0]);
      wr(IDX_WT_HI, v[15:8]);
      wr(IDX_CU_CTRL, ZERO8);
      wr(IDX_PIFLAGS, ZERO8);
      wr(IDX_CU_CTRL, {4'h0, 4'(m)});
      k = (m == 6) ? 4 : (m == 7) ? 16 : 1;
      repeat (k - 1) pin_pulse();
      if (m == 4) i_tpc_pin_model.drive(1'b1);
      rd(IDX_PIFLAGS, "no capture yet", ZERO8);
      if (m == 4) i_tpc_pin_model.drive(1'b0);
      else pin_pulse();
      rd(IDX_PIFLAGS, "capture flag", 8'h04);
      rd(IDX_CAP_LO, "capture lo", v[7:0]);
      rd(IDX_CAP_HI, "capture hi", v[15:8]);
    end
    wr(IDX_CU_CTRL, {4'h0, M_CAP_RISE4});
    repeat (2) pin_pulse();
    wr(IDX_CU_CTRL, ZERO8);
    wr(IDX_PIFLAGS, ZERO8);
    wr(IDX_CU_CTRL, {4'h0, M_CAP_RISE4});
    repeat (3) pin_pulse();
    rd(IDX_PIFLAGS, "prescaler cleared", ZERO8);
    for (int m = 8; m < 12; m++) begin
      v = 16'($urandom_range(1, 65535));
      wr(IDX_CU_CTRL, ZERO8);
      wr(IDX_WT_LO, v[7:0]);
      wr(IDX_WT_HI, v[15:8]);
      wr(IDX_CAP_LO, v[7:0]);
      wr(IDX_CAP_HI, v[15:8]);
      wr(IDX_PIFLAGS, ZERO8);
      wr(IDX_CU_CTRL, {4'h3, 4'(m)});
      rd(IDX_PIFLAGS, "compare flag", 8'h04);
      rd(IDX_CU_CTRL, "duty bits", mdl[IDX_CU_CTRL]);
      rd(IDX_WT_HI, "trigger reset", (m == 11) ? ZERO8 : v[15:8]);
    end
    check("trigger pulses", 16'(trig_n), 16'h0001);
    // capture pair zero keeps the trigger firing; a low byte write must still land
    wr(IDX_CAP_LO, ZERO8);
    wr(IDX_CAP_HI, ZERO8);
    wr(IDX_WT_LO, 8'h33);
    rd(IDX_WT_LO, "write beats trigger", 8'h33);
    // running timer reaching the compare value ffff is reset without overflow flag
    wr(IDX_CAP_LO, 8'hff);
    wr(IDX_CAP_HI, 8'hff);
    wr(IDX_WT_HI, 8'hff);
    wr(IDX_WT_LO, 8'hf0);
    wr(IDX_PIFLAGS, ZERO8);
    wr(IDX_WT_CTRL, 8'h09);
    repeat (30) @(posedge pclk);
    rd(IDX_PIFLAGS, "trigger no overflow", 8'h04);
    wr(IDX_CU_CTRL, ZERO8);
    wr(IDX_WT_HI, 8'hff);
    wr(IDX_WT_LO, 8'hf0);
    wr(IDX_PIFLAGS, ZERO8);
    repeat (30) @(posedge pclk);
    rd(IDX_PIFLAGS, "plain overflow", 8'h01);
    wr(IDX_WT_CTRL, 8'h08);
    wr(IDX_CU_CTRL, ZERO8);
    wr(IDX_WT_LO, 8'h5a);
    wr(IDX_WT_HI, 8'ha5);
    wr(IDX_PT_PERIOD, 8'h20);
    wr(IDX_PT_COUNT, 8'h10);
    wr(IDX_PT_CTRL, 8'h78);
    rd(IDX_PT_COUNT, "count kept", 8'h10);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_WT_LO, "wide lo kept", 8'h5a);
    rd(IDX_WT_HI, "wide hi kept", 8'ha5);
    rd(IDX_WT_CTRL, "wctrl kept", 8'h08);
    rd(IDX_PT_PERIOD, "period reset", PERIOD_RESET);
    rd(IDX_PT_COUNT, "count reset", ZERO8);
    for (int c = 0; c < 4; c++) begin
      p = $urandom_range(1, 15);
      d = (c == 0) ? 1 : (c == 1) ? 4 : 16;
      wr(IDX_PT_PERIOD, 8'(p));
      wr(IDX_PT_CTRL, 8'(4 + c));
      wait_pulses(3);
      check("period", 16'(pulse_cyc[$] - pulse_cyc[$-1]), 16'((p + 1) * d));
    end
    wr(IDX_PT_CTRL, ZERO8);
    n0 = pulse_cyc.size();
    repeat (300) @(posedge pclk);
    check("stopped", 16'(pulse_cyc.size() - n0), 16'h0000);
    k = $urandom_range(2, 16);
    wr(IDX_CU_CTRL, ZERO8);
    wr(IDX_PT_PERIOD, 8'h07);
    wr(IDX_PIFLAGS, ZERO8);
    wr(IDX_PT_COUNT, ZERO8);
    wr(IDX_PT_CTRL, {1'b0, 4'(k - 1), 3'b110});
    wait_pulses(k - 1);
    repeat (10) @(posedge pclk);
    rd(IDX_PIFLAGS, "postscale early", ZERO8);
    wait_pulses(1);
    repeat (10) @(posedge pclk);
    rd(IDX_PIFLAGS, "postscale flag", 8'h02);
    end_sim();
  end
endmodule

// File: sim/tpc_pin_model.sv
// Purpose: event pin and timer crystal as seen from outside the block
// Assumes: pin edges are made only when the bench asks for them
// Notes:   crystal toggles only while its enable is high
`timescale 1ns/1ps
module tpc_pin_model (
  input  wire logic pclk,
  input  wire logic timer_osc_enable,
  output logic      event_pin,
  output logic      osc_clock
);
  initial event_pin = 1'b0;
  initial osc_clock = 1'b0;
  // 200 khz crystal, stands still while disabled
  always #2500 osc_clock = (timer_osc_enable === 1'b1) ? ~osc_clock : 1'b0;
  // set the pin level just after an edge, then hold it
  task automatic drive(input logic lvl);
    @(posedge pclk);
    event_pin <= lvl;
    repeat (6) @(posedge pclk);
  endtask
endmodule
